// ==== shared/isle_pkg.sv ====
// isle_pkg: opcodes, field positions, reset values for the increment/or-literal executor
// assumes a 14-bit instruction word and an 8-bit data path
package isle_pkg;
  localparam int          INSTR_W        = 14;
  localparam int          DATA_W         = 8;
  localparam int          FADDR_W        = 7;
  // opcode field position
  localparam int          OPC_HI         = 13;
  localparam int          OPC_LO         = 8;
  // destination select bit position
  localparam int          DEST_BIT       = 7;
  // file address and literal field positions
  localparam int          FADDR_HI       = 6;
  localparam int          LIT_HI         = 7;
  // opcodes (top six bits)
  localparam logic [5:0]  OPC_INC_SKIP   = 6'h0F;
  localparam logic [5:0]  OPC_INC_FILE   = 6'h0A;
  localparam logic [5:0]  OPC_OR_LIT     = 6'h38;
  // destination select values
  localparam logic        DEST_WREG      = 1'b0;
  localparam logic        DEST_FILE      = 1'b1;
  // reset values and byte constants
  localparam logic [7:0]  WREG_RST       = 8'h00;
  localparam logic        ZFLAG_RST      = 1'b0;
  localparam logic [7:0]  ONE_8          = 8'h01;
  localparam logic [7:0]  ZERO_8         = 8'h00;

  typedef enum logic [1:0] {
    ISLE_OP_NONE,
    ISLE_OP_INC_SKIP,
    ISLE_OP_INC_FILE,
    ISLE_OP_OR_LIT
  } isle_op_t;
endpackage : isle_pkg

// ==== verilog/isle_decode.sv ====
// isle_decode: splits an instruction word into operation, destination, address, literal
// assumes a valid 14-bit word from the fetch stage; purely combinational
`timescale 1ns/1ns
`default_nettype none
module isle_decode (
  input  wire logic [13:0]         instr,
  output isle_pkg::isle_op_t       op,
  output logic                     dest_sel,
  output logic [6:0]               faddr,
  output logic [7:0]               literal
);
  // opcode field
  wire logic [5:0] opc_w = instr[isle_pkg::OPC_HI:isle_pkg::OPC_LO];

  wire logic is_inc_skip = (opc_w == isle_pkg::OPC_INC_SKIP);
  wire logic is_inc_file = (opc_w == isle_pkg::OPC_INC_FILE);
  wire logic is_or_lit   = (opc_w == isle_pkg::OPC_OR_LIT);

  // operation select, others fall to none
  assign op = is_inc_skip ? isle_pkg::ISLE_OP_INC_SKIP :
              is_inc_file ? isle_pkg::ISLE_OP_INC_FILE :
              is_or_lit   ? isle_pkg::ISLE_OP_OR_LIT   : isle_pkg::ISLE_OP_NONE;

  // field extraction
  assign dest_sel = instr[isle_pkg::DEST_BIT];
  assign faddr    = instr[isle_pkg::FADDR_HI:0];
  assign literal  = instr[isle_pkg::LIT_HI:0];
endmodule : isle_decode
`default_nettype wire

// ==== verilog/isle_exec.sv ====
// isle_exec: executes increment-skip, increment and or-literal instructions
// assumes fetch presents one word per instruction cycle with instr_valid, and
// the register file returns the addressed byte combinationally on file_rdata
//
// Contract
// - 001111 decodes increment-and-skip, d, 7-bit address
// - 001010 decodes plain increment, same layout
// - d=0 writes result to working register
// - d=1 writes result back to file
// - zero skip result discards fetched next instruction
// - skip runs no-operation, two cycles total
// - increment wraps eight bits, FF to 00
// - 111000 decodes literal or, 8-bit literal
// - or working register with literal
// - or result to working register, one cycle
`timescale 1ns/1ns
`default_nettype none
module isle_exec (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                instr_valid,  // instruction word present this cycle
  input  wire logic [13:0]         instr,
  output logic [6:0]               file_addr,    // read and write address to file
  input  wire logic [7:0]          file_rdata,
  output logic                     file_we,      // one-cycle write strobe
  output logic [7:0]               file_wdata,
  output logic [7:0]               wreg,         // working register
  output logic                     zflag,        // zero flag of status
  output logic                     skip_active,  // current slot is a no_operation
  output logic                     instr_done    // one instruction completed
);
  isle_pkg::isle_op_t op;
  logic                dest_sel;
  logic [6:0]          faddr;
  logic [7:0]          literal;

  logic [7:0]          wreg_q;
  logic [7:0]          wreg_d;
  logic                zflag_q;
  logic                zflag_d;
  logic                skip_q;
  logic                skip_d;

  // field decode
  isle_decode u_decode (
    .instr    (instr),
    .op       (op),
    .dest_sel (dest_sel),
    .faddr    (faddr),
    .literal  (literal)
  );

  // a word is executed only when valid and not in the discarded slot
  wire logic exec_en   = instr_valid && !skip_q;
  wire logic is_skip   = (op == isle_pkg::ISLE_OP_INC_SKIP);
  wire logic is_inc    = (op == isle_pkg::ISLE_OP_INC_FILE);
  wire logic is_or     = (op == isle_pkg::ISLE_OP_OR_LIT);
  wire logic any_inc   = is_skip || is_inc;

  wire logic [7:0] inc_res = file_rdata + isle_pkg::ONE_8;
  wire logic [7:0] or_res  = wreg_q | literal;
  wire logic       inc_zero = (inc_res == isle_pkg::ZERO_8);
  wire logic       or_zero  = (or_res == isle_pkg::ZERO_8);

  // file port: address always from the word, write only for d=1 increments
  assign file_addr  = faddr;
  assign file_we    = exec_en && any_inc && (dest_sel == isle_pkg::DEST_FILE);
  assign file_wdata = inc_res;

  // next working register, zero flag and skip state
  always_comb begin
    wreg_d  = wreg_q;
    zflag_d = zflag_q;
    skip_d  = 1'b0;           // discarded slot lasts one instruction
    if (exec_en) begin
      case (op)
        isle_pkg::ISLE_OP_INC_SKIP: begin
          if (dest_sel == isle_pkg::DEST_WREG) begin
            wreg_d = inc_res;
          end
          skip_d = inc_zero;
        end
        isle_pkg::ISLE_OP_INC_FILE: begin
          if (dest_sel == isle_pkg::DEST_WREG) begin
            wreg_d = inc_res;
          end
          zflag_d = inc_zero;
        end
        isle_pkg::ISLE_OP_OR_LIT: begin
          wreg_d  = or_res;
          zflag_d = or_zero;
        end
        default: begin
          wreg_d  = wreg_q;
        end
      endcase
    end else if (skip_q && !instr_valid) begin
      skip_d = 1'b1;          // hold discard until the fetched word arrives
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wreg_q  <= isle_pkg::WREG_RST;
      zflag_q <= isle_pkg::ZFLAG_RST;
      skip_q  <= 1'b0;
    end else begin
      wreg_q  <= wreg_d;
      zflag_q <= zflag_d;
      skip_q  <= skip_d;
    end
  end

  assign wreg        = wreg_q;
  assign zflag       = zflag_q;
  assign skip_active = skip_q;
  // done on the one-cycle path, or at the end of the no_operation slot
  assign instr_done  = instr_valid && (skip_q || !(is_skip && inc_zero)) &&
                       (skip_q || any_inc || is_or || op == isle_pkg::ISLE_OP_NONE);
endmodule : isle_exec
`default_nettype wire

// ==== testbench/isle_regfile.sv ====
// isle_regfile: 128-byte file model with combinational read
// assumes writes are strobed by we at the clk_sys rise
`timescale 1ns/1ns
`default_nettype none
module isle_regfile (
  input  wire logic       clk_sys,
  input  wire logic [6:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);
  logic [7:0] mem [128];
  // read is same cycle, write lands at the edge
  assign rdata = mem[addr];
  always @(posedge clk_sys) if (we) mem[addr] <= wdata;
endmodule : isle_regfile
`default_nettype wire

// ==== testbench/isle_exec_sva.sv ====
// isle_exec_sva: port timing checks of the executor
// assumes one clock domain with async active-low reset
`timescale 1ns/1ns
`default_nettype none
module isle_exec_sva (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        instr_valid,
  input wire logic        file_we,
  input wire logic        zflag,
  input wire logic        skip_active,
  input wire logic        instr_done,
  input wire logic [13:0] instr,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  wreg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // executing slot and increment decode
  wire logic run  = instr_valid && !skip_active;
  wire logic inc  = run && (instr[13:8] == 6'h0F || instr[13:8] == 6'h0A);
  wire logic tsk  = run && instr[13:8] == 6'h0F && file_rdata == 8'hFF;
  a_addr_field: assert property (file_addr == instr[6:0]) else $error("addr");
  a_wdata_wrap: assert property (inc |-> file_wdata == 8'(file_rdata + 8'h01))
    else $error("wrap");
  a_file_write: assert property (file_we == (inc && instr[7])) else $error("we");
  a_wreg_inc: assert property (inc && !instr[7] |=> wreg == 8'($past(file_rdata) + 8'h01))
    else $error("winc");
  a_or_lit: assert property (run && instr[13:8] == 6'h38 |=>
    wreg == ($past(wreg) | $past(instr[7:0])) && zflag == (wreg == 8'h00)) else $error("or");
  a_skip_set: assert property (run && instr[13:8] == 6'h0F |=>
    skip_active == ($past(file_rdata) == 8'hFF) && $stable(zflag)) else $error("skip");
  a_inc_zero: assert property (run && instr[13:8] == 6'h0A |=>
    zflag == ($past(file_rdata) == 8'hFF)) else $error("z");
  a_skip_slot: assert property (skip_active && instr_valid |-> !file_we ##1
    !skip_active && $stable(wreg) && $stable(zflag)) else $error("slot");
  a_done_pulse: assert property (instr_done == (instr_valid && !tsk))
    else $error("done");
  cover property (inc && file_rdata == 8'hFF);
  cover property (skip_active && instr_valid);
  cover property (run && instr[13:8] == 6'h38);
  cover property (tsk ##1 skip_active && !instr_valid);
endmodule : isle_exec_sva
bind isle_exec isle_exec_sva u_sva (.*);
`default_nettype wire

// ==== testbench/isle_exec_bench.sv ====
// isle_exec_bench: random instruction stream against a behavioural model
// assumes the file model answers reads in the same cycle
`timescale 1ns/1ns
`default_nettype none
module isle_exec_bench;
  logic clk_sys = 0, arst_n = 0, instr_valid = 0, file_we, zflag, skip_active, instr_done;
  logic [13:0] instr = 14'h0000;
  logic [6:0] file_addr;
  logic [7:0] file_rdata, file_wdata, wreg, m_w = 8'h00, r, m_mem [128];
  logic m_z = 0, m_s = 0;
  logic [5:0] ops [4] = '{6'h0F, 6'h0A, 6'h38, 6'h08};
  int fail_count = 0, n_tests = 0, i;
  always #5 clk_sys = ~clk_sys;
  isle_exec uut (.*);
  isle_regfile rf (.clk_sys(clk_sys), .addr(file_addr), .we(file_we), .wdata(file_wdata),
    .rdata(file_rdata));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // stimulus, model step and comparison each cycle
  initial begin
    void'($urandom(32'hE5BE));
    for (i = 0; i < 128; i++) begin
      m_mem[i] = ($urandom % 3 == 0) ? 8'hFF : 8'($urandom);
      rf.mem[i] = m_mem[i];
    end
    repeat (4) @(posedge clk_sys);
    arst_n <= 1;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      instr_valid <= ($urandom % 6 != 0);
      instr <= {ops[$urandom % 4], 8'($urandom)};
      @(negedge clk_sys);
      chk(wreg, m_w);
      chk(zflag, m_z);
      chk(skip_active, m_s);
      r = m_mem[instr[6:0]] + 8'h01;
      chk(file_we, instr_valid && !m_s && instr[7] &&
        (instr[13:8] == 6'h0F || instr[13:8] == 6'h0A));
      chk(instr_done, instr_valid && !(!m_s && instr[13:8] == 6'h0F && r == 8'h00));
      if (file_we) chk(file_wdata, r);
      if (instr_valid && m_s) m_s = 0;
      else if (instr_valid) case (instr[13:8])
        6'h0F, 6'h0A: begin
          if (instr[7]) m_mem[instr[6:0]] = r;
          else m_w = r;
          if (instr[13:8] == 6'h0A) m_z = (r == 8'h00);
          else m_s = (r == 8'h00);
        end
        6'h38: begin
          m_w = m_w | instr[7:0];
          m_z = (m_w == 8'h00);
        end
        default: ;
      endcase
    end
    @(negedge clk_sys);
    for (i = 0; i < 128; i++) chk(rf.mem[i], m_mem[i]);
    end_of_test();
  end
endmodule : isle_exec_bench
`default_nettype wire
